/* core/sbrg_core.v */
// Baud rate generator, divisor registers and second port pin routing
`timescale 1ns/1ps
`include "sbrg_consts.vh"

module sbrg_core (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire [2:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       break_detect_flag,
  input  wire       rx_edge_flag,
  output wire       break_irq,
  output wire       rx_edge_irq,
  output reg        os_tick,
  output reg        bit_tick,
  output wire       gen_running,
  input  wire       port_two_tx_line,
  output wire       port_two_rx_line,
  output wire       pin_pair_a_tx,
  output wire       pin_pair_b_tx,
  input  wire       pin_pair_a_rx,
  input  wire       pin_pair_b_rx
);

  // Register state
  reg  [7:0]               bdh_reg;
  reg  [7:0]               bdh_next;
  reg  [4:0]               div_hi_reg;
  reg  [4:0]               div_hi_next;
  reg  [7:0]               bdl_reg;
  reg  [7:0]               bdl_next;
  reg  [7:0]               opt_reg;
  reg  [7:0]               opt_next;
  reg  [7:0]               ctl2_reg;
  reg  [7:0]               ctl2_next;
  reg                      armed_reg;
  reg                      armed_next;

  // Rate generator state
  reg  [`SBRG_DIV_W-1:0]   cnt_reg;
  reg  [`SBRG_DIV_W-1:0]   cnt_next;
  reg  [3:0]               os_cnt_reg;
  reg  [3:0]               os_cnt_next;
  reg                      os_tick_next;
  reg                      bit_tick_next;

  // Decoded strobes and derived values
  wire                     wr_bdh;
  wire                     wr_bdl;
  wire                     wr_opt;
  wire                     wr_ctl2;
  wire                     arm_req;
  wire [`SBRG_DIV_W-1:0]   divisor;
  wire [`SBRG_DIV_W-1:0]   div_last;
  wire                     cnt_wrap;
  wire                     pin_sel;

  function wr_hit;
    input [2:0] a;
    input [2:0] target;
    input       we;
    begin
      wr_hit = we && (a == target);
    end
  endfunction

  // Reading the high register hides its unused bit
  function [7:0] bdh_view;
    input [7:0] raw;
    begin
      bdh_view = raw & `SBRG_BDH_RD_MASK;
    end
  endfunction

  assign wr_bdh  = wr_hit(reg_addr, `SBRG_ADDR_BDH, reg_wr);
  assign wr_bdl  = wr_hit(reg_addr, `SBRG_ADDR_BDL, reg_wr);
  assign wr_opt  = wr_hit(reg_addr, `SBRG_ADDR_OPT, reg_wr);
  assign wr_ctl2 = wr_hit(reg_addr, `SBRG_ADDR_CTL2, reg_wr);
  assign arm_req = wr_ctl2 && (reg_wdata[`SBRG_TX_EN_BIT] || reg_wdata[`SBRG_RX_EN_BIT]);

  assign divisor     = {div_hi_reg, bdl_reg};
  assign div_last    = divisor - `SBRG_DIV_ONE;
  assign cnt_wrap    = (cnt_reg >= div_last);
  assign pin_sel     = opt_reg[`SBRG_PS_BIT];
  assign gen_running = armed_reg && (divisor != {`SBRG_DIV_W{1'b0}});

  // High half is buffered; only the low write moves it into the divisor
  always @* begin
    bdh_next    = bdh_reg;
    div_hi_next = div_hi_reg;
    bdl_next    = bdl_reg;
    if (wr_bdh) begin
      bdh_next = reg_wdata;
    end
    if (wr_bdl) begin
      bdl_next    = reg_wdata;
      div_hi_next = bdh_reg[`SBRG_DIV_HI_MSB:0];
    end
  end

  always @* begin
    opt_next   = opt_reg;
    ctl2_next  = ctl2_reg;
    armed_next = armed_reg;
    if (wr_opt) begin
      opt_next = reg_wdata & `SBRG_OPT_MASK;
    end
    if (wr_ctl2) begin
      ctl2_next = reg_wdata;
    end
    // Arming is sticky until reset
    if (arm_req) begin
      armed_next = 1'b1;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bdh_reg <= `SBRG_BDH_RESET;
    end else begin
      bdh_reg <= bdh_next;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_hi_reg <= `SBRG_DIV_HI_RESET;
    end else begin
      div_hi_reg <= div_hi_next;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bdl_reg <= `SBRG_BDL_RESET;
    end else begin
      bdl_reg <= bdl_next;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      opt_reg <= `SBRG_OPT_RESET;
    end else begin
      opt_reg <= opt_next;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl2_reg <= `SBRG_CTL2_RESET;
    end else begin
      ctl2_reg <= ctl2_next;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
    end
  end

  // Counter held at zero while stopped, so nothing toggles when idle
  always @* begin
    cnt_next      = cnt_reg;
    os_cnt_next   = os_cnt_reg;
    os_tick_next  = 1'b0;
    bit_tick_next = 1'b0;
    if (!gen_running) begin
      cnt_next    = {`SBRG_DIV_W{1'b0}};
      os_cnt_next = 4'h0;
    end else if (cnt_wrap) begin
      cnt_next      = {`SBRG_DIV_W{1'b0}};
      os_cnt_next   = os_cnt_reg + 4'h1;
      os_tick_next  = 1'b1;
      bit_tick_next = (os_cnt_reg == `SBRG_OS_LAST);
    end else begin
      cnt_next = cnt_reg + `SBRG_DIV_ONE;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg    <= {`SBRG_DIV_W{1'b0}};
      os_cnt_reg <= 4'h0;
      os_tick    <= 1'b0;
      bit_tick   <= 1'b0;
    end else begin
      cnt_reg    <= cnt_next;
      os_cnt_reg <= os_cnt_next;
      os_tick    <= os_tick_next;
      bit_tick   <= bit_tick_next;
    end
  end

  always @* begin
    case (reg_addr)
      `SBRG_ADDR_BDH:  reg_rdata = bdh_view(bdh_reg);
      `SBRG_ADDR_BDL:  reg_rdata = bdl_reg;
      `SBRG_ADDR_OPT:  reg_rdata = opt_reg;
      `SBRG_ADDR_CTL2: reg_rdata = ctl2_reg;
      default:         reg_rdata = 8'h00;
    endcase
  end

  // Interrupt enables act at once; only the divisor half is buffered
  assign break_irq   = bdh_reg[`SBRG_BRK_IE_BIT] & break_detect_flag;
  assign rx_edge_irq = bdh_reg[`SBRG_EDGE_IE_BIT] & rx_edge_flag;

  // Unselected transmit pin rests at the idle high level
  assign pin_pair_a_tx    = pin_sel ? 1'b1 : port_two_tx_line;
  assign pin_pair_b_tx    = pin_sel ? port_two_tx_line : 1'b1;
  assign port_two_rx_line = pin_sel ? pin_pair_b_rx : pin_pair_a_rx;

endmodule // sbrg_core

/* dv/sbrg_chk.sv */
// Port-level checks for the baud rate generator
`timescale 1ns/1ps
module sbrg_chk (
  input logic       ref_clk,
  input logic       rst,
  input logic [2:0] reg_addr,
  input logic       reg_wr,
  input logic [7:0] reg_rdata,
  input logic       break_detect_flag,
  input logic       rx_edge_flag,
  input logic       break_irq,
  input logic       rx_edge_irq,
  input logic       os_tick,
  input logic       bit_tick,
  input logic       gen_running,
  input logic       port_two_tx_line,
  input logic       port_two_rx_line,
  input logic       pin_pair_a_tx,
  input logic       pin_pair_b_tx,
  input logic       pin_pair_a_rx,
  input logic       pin_pair_b_rx
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_brk_irq: assert property (reg_addr==0 |->
    break_irq==(reg_rdata[7]&break_detect_flag)) else $error("irq");
  a_edge_irq: assert property (reg_addr==0 |->
    rx_edge_irq==(reg_rdata[6]&rx_edge_flag)) else $error("irq");
  a_route_a: assert property (reg_addr==2 && !reg_rdata[0] |->
    pin_pair_a_tx==port_two_tx_line && port_two_rx_line==pin_pair_a_rx) else $error("route");
  a_route_b: assert property (reg_addr==2 && reg_rdata[0] |->
    pin_pair_b_tx==port_two_tx_line && port_two_rx_line==pin_pair_b_rx) else $error("route");
  a_stop_idle: assert property (!gen_running |=> !os_tick) else $error("tick");
  a_arm_write: assert property ($rose(gen_running) |->
    $past(reg_wr && reg_addr!=0)) else $error("arm");
  a_bit_gap: assert property (bit_tick |=> !bit_tick[*8]) else $error("bit");
  a_bit_os: assert property (bit_tick |-> os_tick) else $error("bit");
  c_os: cover property (os_tick);
  c_bit: cover property (bit_tick);
  c_brk: cover property (break_irq);
endmodule // sbrg_chk

/* dv/test_sbrg_core.sv */
// Directed bench for the baud rate generator
`timescale 1ns/1ps
module test_sbrg_core;
  logic ref_clk=0, rst=1, reg_wr=0, break_detect_flag=0, rx_edge_flag=0;
  logic port_two_tx_line=1, pin_pair_a_rx=1, pin_pair_b_rx=0;
  logic [2:0] reg_addr=0;
  logic [7:0] reg_wdata=0;
  wire  [7:0] reg_rdata;
  wire break_irq, rx_edge_irq, os_tick, bit_tick, gen_running;
  wire port_two_rx_line, pin_pair_a_tx, pin_pair_b_tx;
  int n_mismatch=0, samples_checked=0, o, b;
  always #12.5 ref_clk = ~ref_clk;
  sbrg_core DUT (
    .ref_clk           (ref_clk),
    .rst               (rst),
    .reg_addr          (reg_addr),
    .reg_wr            (reg_wr),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .break_detect_flag (break_detect_flag),
    .rx_edge_flag      (rx_edge_flag),
    .break_irq         (break_irq),
    .rx_edge_irq       (rx_edge_irq),
    .os_tick           (os_tick),
    .bit_tick          (bit_tick),
    .gen_running       (gen_running),
    .port_two_tx_line  (port_two_tx_line),
    .port_two_rx_line  (port_two_rx_line),
    .pin_pair_a_tx     (pin_pair_a_tx),
    .pin_pair_b_tx     (pin_pair_b_tx),
    .pin_pair_a_rx     (pin_pair_a_rx),
    .pin_pair_b_rx     (pin_pair_b_rx)
  );
  // One write, then an idle cycle so back-to-back calls never re-raise the strobe in one step
  task wr(input [2:0] a, input [7:0] d);
    reg_addr=a; reg_wdata=d; reg_wr=1; @(negedge ref_clk); reg_wr=0; @(negedge ref_clk);
  endtask
  task chk(input [7:0] g, input [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++; $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Counts both ticks over n settled cycles
  task cnt(input int n);
    o=0; b=0;
    repeat (n) begin @(posedge ref_clk); #1; o+=os_tick; b+=bit_tick; end
    @(negedge ref_clk);
  endtask
  task give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch==0 && samples_checked>0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin #1000000; n_mismatch++; give_verdict; end
  initial begin
    repeat (6) @(negedge ref_clk); rst=0;
    wr(5,8'hFF);
    for (int a=0; a<6; a++) begin reg_addr=a; #1 chk(reg_rdata, a==1 ? 8'h04 : 8'h00); end
    chk(gen_running,0);
    wr(0,8'hE0); reg_addr=0; #1 chk(reg_rdata,8'hC0);
    break_detect_flag=1; rx_edge_flag=1; #1 chk({break_irq,rx_edge_irq},3);
    wr(0,0); #1 chk({break_irq,rx_edge_irq},0);
    chk(gen_running,0);
    wr(1,8'h02); wr(3,8'h04); cnt(64); chk(o,32); chk(b,2);
    wr(0,8'h01); cnt(32); chk(o,16);
    wr(1,0); cnt(512); chk(o,2);
    wr(0,0); wr(1,0); cnt(20); chk(o,0); chk(gen_running,0);
    port_two_tx_line=0; reg_addr=2;
    #1 chk({pin_pair_a_tx,pin_pair_b_tx,port_two_rx_line},3'b011);
    wr(2,1); #1 chk({pin_pair_a_tx,pin_pair_b_tx,port_two_rx_line},3'b100);
    give_verdict;
  end
endmodule // test_sbrg_core
bind sbrg_core sbrg_chk u_chk (
  .ref_clk           (ref_clk),
  .rst               (rst),
  .reg_addr          (reg_addr),
  .reg_wr            (reg_wr),
  .reg_rdata         (reg_rdata),
  .break_detect_flag (break_detect_flag),
  .rx_edge_flag      (rx_edge_flag),
  .break_irq         (break_irq),
  .rx_edge_irq       (rx_edge_irq),
  .os_tick           (os_tick),
  .bit_tick          (bit_tick),
  .gen_running       (gen_running),
  .port_two_tx_line  (port_two_tx_line),
  .port_two_rx_line  (port_two_rx_line),
  .pin_pair_a_tx     (pin_pair_a_tx),
  .pin_pair_b_tx     (pin_pair_b_tx),
  .pin_pair_a_rx     (pin_pair_a_rx),
  .pin_pair_b_rx     (pin_pair_b_rx)
);

/* inc/sbrg_consts.vh */
// Constants for the serial port baud rate generator and pin routing
`ifndef SBRG_CONSTS_VH
`define SBRG_CONSTS_VH

`define SBRG_ADDR_BDH      3'h0
`define SBRG_ADDR_BDL      3'h1
`define SBRG_ADDR_OPT      3'h2
`define SBRG_ADDR_CTL2     3'h3
`define SBRG_BDH_RESET     8'h00
`define SBRG_BDL_RESET     8'h04
`define SBRG_OPT_RESET     8'h00
`define SBRG_CTL2_RESET    8'h00
`define SBRG_BRK_IE_BIT    7
`define SBRG_EDGE_IE_BIT   6
`define SBRG_DIV_HI_MSB    4
`define SBRG_DIV_HI_RESET  5'h00
`define SBRG_PS_BIT        0
`define SBRG_OPT_MASK      8'h01
`define SBRG_BDH_RD_MASK   8'hDF
`define SBRG_TX_EN_BIT     3
`define SBRG_RX_EN_BIT     2
`define SBRG_DIV_W         13
`define SBRG_DIV_ONE       13'h0001
`define SBRG_OVERSAMPLE    5'h10
`define SBRG_OS_LAST       4'hF

`endif
